// ==== core/flbs_pacer.sv ====
`timescale 1ns/1ps
// Frame start pacer: spreads frames so the wire load equals rate percent
module flbs_pacer
  import flbs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control
  input wire logic run_i,
  input wire logic [7:0] rate_pct_i,
  input wire logic [15:0] frame_bytes_i,
  // Frame start request
  output logic tick_o
);
  logic [31:0] acc_q, acc_d;
  logic [31:0] cost;

  // Credit accumulator: each cycle earns rate_pct, a frame costs 100 x wire bytes [R16]
  always_comb begin
    cost = 32'(frame_bytes_i + FLBS_WIRE_OVERHEAD) * 32'(FLBS_FULL_RATE_PCT);
    acc_d = acc_q;
    tick_o = 1'b0;
    if (!run_i) begin
      acc_d = cost;
    end else if (acc_q >= cost) begin
      tick_o = 1'b1;
      acc_d = acc_q - cost + 32'(rate_pct_i);
    end else begin
      acc_d = acc_q + 32'(rate_pct_i);
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= 32'h0;
    end else begin
      acc_q <= acc_d;
    end
  end
endmodule : flbs_pacer

// ==== core/flbs_pkg.sv ====
package flbs_pkg;
  // Register map, word addresses on a 32-bit Avalon-MM slave
  localparam logic [3:0] FLBS_REG_CTRL = 4'h0;
  localparam logic [3:0] FLBS_REG_STATUS = 4'h1;
  localparam logic [3:0] FLBS_REG_LOSS_STEP = 4'h2;
  localparam logic [3:0] FLBS_REG_TRIAL_SEC = 4'h3;
  localparam logic [3:0] FLBS_REG_FRAME_SIZE = 4'h4;
  localparam logic [3:0] FLBS_REG_CEILING = 4'h5;
  localparam logic [3:0] FLBS_REG_THRESH = 4'h6;
  localparam logic [3:0] FLBS_REG_ITER = 4'h7;
  localparam logic [3:0] FLBS_REG_RATE = 4'h8;
  localparam logic [3:0] FLBS_REG_TX_CNT = 4'h9;
  localparam logic [3:0] FLBS_REG_RX_CNT = 4'ha;
  localparam logic [3:0] FLBS_REG_LOSS_PPM = 4'hb;
  localparam logic [3:0] FLBS_REG_BURST_RES = 4'hc;
  localparam logic [3:0] FLBS_REG_BURST_LEN = 4'hd;
  // Control fields
  localparam int FLBS_CTRL_LOSS_EN = 0;
  localparam int FLBS_CTRL_BURST_EN = 1;
  localparam int FLBS_CTRL_START = 2;
  // Reset values, and the clean-run count that ends the loss sweep
  localparam logic [7:0] FLBS_FULL_RATE_PCT = 8'h64; // 100 percent
  localparam logic [7:0] FLBS_LOSS_STEP_RST = 8'h0a; // 10 percent
  localparam logic [15:0] FLBS_TRIAL_SEC_RST = 16'h0002;
  localparam logic [15:0] FLBS_FRAME_SIZE_RST = 16'h0040;
  localparam logic [31:0] FLBS_CEILING_RST = 32'h0000_1000;
  localparam logic [31:0] FLBS_THRESH_RST = 32'h0000_0001;
  localparam logic [15:0] FLBS_ITER_RST = 16'h0032; // 50 bursts
  localparam logic [1:0] FLBS_LOSS_FREE_RUNS = 2'h2;
  // Timing: one second as a cycle count at 200 MHz
  localparam int FLBS_CLK_HZ = 200000000;
  localparam int FLBS_SEC_CYCLES = FLBS_CLK_HZ;
  // Ethernet overhead per frame on the wire: preamble plus minimum gap, bytes
  localparam logic [15:0] FLBS_WIRE_OVERHEAD = 16'h0014;

  typedef enum logic [2:0] {
    FLBS_IDLE = 3'b000,
    FLBS_LOSS_RUN = 3'b001,
    FLBS_LOSS_EVAL = 3'b011,
    FLBS_BURST_RUN = 3'b010,
    FLBS_BURST_WAIT = 3'b110,
    FLBS_BURST_EVAL = 3'b111,
    FLBS_DONE = 3'b101
  } flbs_state_t;

  // Absolute difference of two counts
  function automatic logic [31:0] flbs_absdiff(input logic [31:0] a, input logic [31:0] b);
    flbs_absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : flbs_absdiff
endpackage : flbs_pkg

// ==== core/flbs_sequencer.sv ====
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// [R1] Frame-loss sweep starts its first trial at 100 percent of line rate.
// [R2] Each loss trial counts sent and returned frames and derives loss ratio.
// [R3] After each loss trial the rate drops by the configured percent step.
// [R4] Sweep ends after two consecutive trials with zero lost frames.
// [R5] Frame-loss sweep runs only when its enable is set beforehand.
// [R6] Each trial transmits for the configured duration in seconds.
// [R7] Burst trial sends frames at minimum gap and counts forwarded ones.
// [R8] No loss in a burst lengthens the next burst.
// [R9] Loss in a burst shortens the next burst.
// [R10] Result is the longest burst length passed with no frame lost.
// [R11] Burst cycle defaults to 50 iterations; result is averaged over them.
// [R12] Burst search runs only when its own enable is set beforehand.
// [R13] Burst length never exceeds the configured ceiling.
// [R14] Stop when result changes by less than the threshold; report last result.
// [R15] Each cycle sends the configured number of bursts before evaluating.
// [R16] Rate percent becomes frame spacing using frame size and link rate.
module flbs_sequencer
  import flbs_pkg::*;
#(
  parameter int SEC_CYCLES = FLBS_SEC_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Traffic generator
  output logic tx_frame_o,
  output logic [15:0] tx_frame_bytes_o,
  input wire logic tx_sent_i,
  // Traffic analyser
  input wire logic rx_frame_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  flbs_state_t state_q, state_d;
  logic loss_en_q, loss_en_d, burst_en_q, burst_en_d;
  logic [7:0] step_q, step_d, rate_q, rate_d;
  logic [15:0] trial_sec_q, trial_sec_d, fsize_q, fsize_d, iter_q, iter_d;
  logic [31:0] ceil_q, ceil_d, thresh_q, thresh_d;
  logic [31:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [31:0] loss_ppm_q, loss_ppm_d;
  logic [1:0] clean_q, clean_d;
  logic [31:0] cyc_q, cyc_d;
  logic [15:0] sec_q, sec_d, it_q, it_d;
  logic [31:0] blen_q, blen_d, bsent_q, bsent_d, best_q, best_d;
  logic [31:0] prev_q, prev_d, res_q, res_d;
  logic [47:0] sum_q, sum_d;
  logic [15:0] fbytes_q, fbytes_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic pace_run, pace_tick, sec_tick;
  logic [31:0] avg, step_len;
  logic [63:0] ppm_prod;

  // Pacer turns the current rate into frame spacing
  flbs_pacer u_pacer (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .run_i(pace_run),
    .rate_pct_i(rate_q),
    .frame_bytes_i(fsize_q),
    .tick_o(pace_tick)
  );

  // Bus answers one cycle after the request; wait until the ack flop rises
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o = rdata_q;
  assign tx_frame_o = (state_q == FLBS_LOSS_RUN) ? pace_tick : (state_q == FLBS_BURST_RUN);
  assign tx_frame_bytes_o = fbytes_q;
  assign busy_o = (state_q != FLBS_IDLE) && (state_q != FLBS_DONE);
  assign done_o = (state_q == FLBS_DONE);
  assign pace_run = (state_q == FLBS_LOSS_RUN);
  assign sec_tick = (cyc_q == 32'(SEC_CYCLES - 1));
  // Step is half the current burst length, never less than one frame
  assign step_len = (blen_q >> 1) == 32'h0 ? 32'h1 : (blen_q >> 1);

  // Loss ratio in parts per million from the two trial counts
  always_comb begin
    ppm_prod = 64'(tx_cnt_q - rx_cnt_q) * 64'd1000000;
    if (tx_cnt_q == 32'h0 || rx_cnt_q >= tx_cnt_q) begin
      ppm_prod = 64'h0;
    end else begin
      ppm_prod = ppm_prod / 64'(tx_cnt_q); // [R2]
    end
  end

  // Register file: writes and reads of configuration and results
  always_comb begin
    loss_en_d = loss_en_q;
    burst_en_d = burst_en_q;
    step_d = step_q;
    trial_sec_d = trial_sec_q;
    fsize_d = fsize_q;
    ceil_d = ceil_q;
    thresh_d = thresh_q;
    iter_d = iter_q;
    ack_d = (avs_read_i | avs_write_i) & ~ack_q;
    rdata_d = rdata_q;
    if (avs_write_i && !ack_q && !busy_o) begin
      case (avs_address_i)
        FLBS_REG_CTRL: begin
          loss_en_d = avs_writedata_i[FLBS_CTRL_LOSS_EN];
          burst_en_d = avs_writedata_i[FLBS_CTRL_BURST_EN];
        end
        FLBS_REG_LOSS_STEP: step_d = avs_writedata_i[7:0];
        FLBS_REG_TRIAL_SEC: trial_sec_d = avs_writedata_i[15:0];
        FLBS_REG_FRAME_SIZE: fsize_d = avs_writedata_i[15:0];
        FLBS_REG_CEILING: ceil_d = avs_writedata_i;
        FLBS_REG_THRESH: thresh_d = avs_writedata_i;
        FLBS_REG_ITER: iter_d = (avs_writedata_i[15:0] == 16'h0) ? 16'h1 : avs_writedata_i[15:0];
        default: ;
      endcase
    end
    if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        FLBS_REG_CTRL: rdata_d = {30'h0, burst_en_q, loss_en_q};
        FLBS_REG_STATUS: rdata_d = {26'h0, done_o, busy_o, 1'b0, state_q};
        FLBS_REG_LOSS_STEP: rdata_d = {24'h0, step_q};
        FLBS_REG_TRIAL_SEC: rdata_d = {16'h0, trial_sec_q};
        FLBS_REG_FRAME_SIZE: rdata_d = {16'h0, fsize_q};
        FLBS_REG_CEILING: rdata_d = ceil_q;
        FLBS_REG_THRESH: rdata_d = thresh_q;
        FLBS_REG_ITER: rdata_d = {16'h0, iter_q};
        FLBS_REG_RATE: rdata_d = {24'h0, rate_q};
        FLBS_REG_TX_CNT: rdata_d = tx_cnt_q;
        FLBS_REG_RX_CNT: rdata_d = rx_cnt_q;
        FLBS_REG_LOSS_PPM: rdata_d = loss_ppm_q;
        FLBS_REG_BURST_RES: rdata_d = res_q;
        FLBS_REG_BURST_LEN: rdata_d = blen_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loss_en_q <= 1'b0;
      burst_en_q <= 1'b0;
      step_q <= FLBS_LOSS_STEP_RST;
      trial_sec_q <= FLBS_TRIAL_SEC_RST;
      fsize_q <= FLBS_FRAME_SIZE_RST;
      ceil_q <= FLBS_CEILING_RST;
      thresh_q <= FLBS_THRESH_RST;
      iter_q <= FLBS_ITER_RST; // [R11]
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      loss_en_q <= loss_en_d;
      burst_en_q <= burst_en_d;
      step_q <= step_d;
      trial_sec_q <= trial_sec_d;
      fsize_q <= fsize_d;
      ceil_q <= ceil_d;
      thresh_q <= thresh_d;
      iter_q <= iter_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Sequencer: loss sweep first, then burst search, each only if enabled
  always_comb begin
    state_d = state_q;
    rate_d = rate_q;
    tx_cnt_d = tx_cnt_q;
    rx_cnt_d = rx_cnt_q;
    loss_ppm_d = loss_ppm_q;
    clean_d = clean_q;
    cyc_d = cyc_q;
    sec_d = sec_q;
    it_d = it_q;
    blen_d = blen_q;
    bsent_d = bsent_q;
    best_d = best_q;
    prev_d = prev_q;
    res_d = res_q;
    sum_d = sum_q;
    fbytes_d = fsize_q;
    // Cycle average, only meaningful in the cycle-complete branch below
    avg = 32'h0;
    if (tx_sent_i) begin
      tx_cnt_d = tx_cnt_q + 32'h1; // [R2] [R7]
    end
    if (rx_frame_i) begin
      rx_cnt_d = rx_cnt_q + 32'h1; // [R2] [R7]
    end
    case (state_q)
      FLBS_IDLE: begin
        if (avs_write_i && !ack_q && avs_address_i == FLBS_REG_CTRL && avs_writedata_i[FLBS_CTRL_START]) begin
          rate_d = FLBS_FULL_RATE_PCT; // [R1]
          clean_d = 2'h0;
          tx_cnt_d = 32'h0;
          rx_cnt_d = 32'h0;
          cyc_d = 32'h0;
          sec_d = 16'h0;
          it_d = 16'h0;
          bsent_d = 32'h0;
          blen_d = ceil_q;
          best_d = 32'h0;
          prev_d = 32'h0;
          sum_d = 48'h0;
          if (loss_en_q) begin
            state_d = FLBS_LOSS_RUN; // [R5]
          end else if (burst_en_q) begin
            state_d = FLBS_BURST_RUN; // [R12]
          end else begin
            state_d = FLBS_DONE;
          end
        end
      end
      FLBS_LOSS_RUN: begin
        // Trial time counted in seconds of clock cycles
        cyc_d = sec_tick ? 32'h0 : cyc_q + 32'h1;
        if (sec_tick) begin
          sec_d = sec_q + 16'h1;
          if (sec_q + 16'h1 >= trial_sec_q) begin
            state_d = FLBS_LOSS_EVAL; // [R6]
          end
        end
      end
      FLBS_LOSS_EVAL: begin
        // Decision taken in this one cycle from counts registered by the end of the run
        loss_ppm_d = ppm_prod[31:0]; // [R2]
        clean_d = (rx_cnt_q >= tx_cnt_q) ? clean_q + 2'h1 : 2'h0;
        tx_cnt_d = 32'h0;
        rx_cnt_d = 32'h0;
        sec_d = 16'h0;
        if (clean_d == FLBS_LOSS_FREE_RUNS || rate_q <= step_q) begin
          state_d = burst_en_q ? FLBS_BURST_RUN : FLBS_DONE; // [R4] [R12]
        end else begin
          rate_d = rate_q - step_q; // [R3]
          state_d = FLBS_LOSS_RUN;
        end
      end
      FLBS_BURST_RUN: begin
        // Back-to-back frames at full rate, minimum gap left to the MAC
        bsent_d = bsent_q + 32'h1; // [R7]
        if (bsent_q + 32'h1 >= blen_q) begin
          state_d = FLBS_BURST_WAIT;
          cyc_d = 32'h0;
        end
      end
      FLBS_BURST_WAIT: begin
        // Drain time for returns: the trial duration in seconds
        cyc_d = sec_tick ? 32'h0 : cyc_q + 32'h1;
        if (sec_tick) begin
          sec_d = sec_q + 16'h1;
          if (sec_q + 16'h1 >= trial_sec_q) begin
            state_d = FLBS_BURST_EVAL; // [R6]
          end
        end
      end
      FLBS_BURST_EVAL: begin
        sec_d = 16'h0;
        bsent_d = 32'h0;
        tx_cnt_d = 32'h0;
        rx_cnt_d = 32'h0;
        if (rx_cnt_q >= tx_cnt_q) begin
          if (blen_q > best_q) best_d = blen_q; // [R10]
          // Grow, clamped at the ceiling
          blen_d = (blen_q + step_len > ceil_q) ? ceil_q : blen_q + step_len; // [R8] [R13]
        end else begin
          blen_d = (blen_q > step_len) ? blen_q - step_len : 32'h1; // [R9]
        end
        it_d = it_q + 16'h1;
        // Every burst of the cycle adds its best length, the last one included
        sum_d = sum_q + 48'(best_d); // [R11]
        if (it_q + 16'h1 >= iter_q) begin
          // Cycle complete: average the best lengths seen per burst
          avg = 32'(sum_d / 48'(iter_q));
          sum_d = 48'h0;
          it_d = 16'h0;
          res_d = avg; // [R11]
          prev_d = avg;
          if (prev_q != 32'h0 && flbs_absdiff(avg, prev_q) < thresh_q) begin
            res_d = avg; // [R14]
            state_d = FLBS_DONE;
          end else begin
            state_d = FLBS_BURST_RUN; // [R15]
          end
        end else begin
          state_d = FLBS_BURST_RUN; // [R15]
        end
      end
      FLBS_DONE: begin
        if (avs_write_i && !ack_q && avs_address_i == FLBS_REG_CTRL) begin
          state_d = FLBS_IDLE;
        end
      end
      default: state_d = FLBS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= FLBS_IDLE;
      rate_q <= FLBS_FULL_RATE_PCT;
      tx_cnt_q <= 32'h0;
      rx_cnt_q <= 32'h0;
      loss_ppm_q <= 32'h0;
      clean_q <= 2'h0;
      cyc_q <= 32'h0;
      sec_q <= 16'h0;
      it_q <= 16'h0;
      blen_q <= 32'h0;
      bsent_q <= 32'h0;
      best_q <= 32'h0;
      prev_q <= 32'h0;
      res_q <= 32'h0;
      sum_q <= 48'h0;
      fbytes_q <= FLBS_FRAME_SIZE_RST;
    end else begin
      state_q <= state_d;
      rate_q <= rate_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      loss_ppm_q <= loss_ppm_d;
      clean_q <= clean_d;
      cyc_q <= cyc_d;
      sec_q <= sec_d;
      it_q <= it_d;
      blen_q <= blen_d;
      bsent_q <= bsent_d;
      best_q <= best_d;
      prev_q <= prev_d;
      res_q <= res_d;
      sum_q <= sum_d;
      fbytes_q <= fbytes_d;
    end
  end
endmodule : flbs_sequencer

// ==== tb/flbs_dut_model.sv ====
`timescale 1ns/1ps
// Device under test: forwards at most buf_cap_i frames of a back-to-back run
module flbs_dut_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link
  input wire logic tx_frame_i,
  input wire logic [15:0] buf_cap_i,
  output logic tx_sent_o,
  output logic rx_frame_o
);
  logic [15:0] run_q;
  // A paced frame is a run of one, so cap 0 drops everything
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q <= 16'h0;
      tx_sent_o <= 1'b0;
      rx_frame_o <= 1'b0;
    end else begin
      run_q <= tx_frame_i ? run_q + 16'h1 : 16'h0;
      tx_sent_o <= tx_frame_i;
      rx_frame_o <= tx_frame_i && (run_q < buf_cap_i);
    end
  end
endmodule : flbs_dut_model

// ==== tb/flbs_sequencer_properties.sv ====
`timescale 1ns/1ps
// Port-level checks on the test sequencer
module flbs_sequencer_properties
  import flbs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Register bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Traffic and status
  input wire logic tx_frame_o,
  input wire logic [15:0] tx_frame_bytes_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // One wait cycle, then the answer
  sequence s_ack;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  AST_ONE_WAIT: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |-> s_ack)
    else $error("bus answer not after one wait cycle");
  AST_IDLE_NO_WAIT: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
    else $error("waitrequest high with no request");
  // Read data must not drift between reads
  AST_READ_HOLD: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  AST_NO_TX_IDLE: assert property (!busy_o |-> !tx_frame_o)
    else $error("frame requested while no test runs");
  // A test starts only in the cycle after a bus write
  AST_START_BY_WRITE: assert property ($rose(busy_o) |-> $past(avs_write_i))
    else $error("test started without a bus write");
  AST_BUSY_ENDS_DONE: assert property ($fell(busy_o) |-> done_o)
    else $error("test ended without reaching done");
  AST_DONE_EXCL: assert property (done_o |-> !busy_o)
    else $error("done and busy together");
  // Only a bus write leaves the finished state
  AST_DONE_HOLD: assert property (done_o && !avs_write_i |=> done_o)
    else $error("done dropped without a write");
  AST_BYTES_RST: assert property ($rose(reset_n_i) |-> tx_frame_bytes_o == FLBS_FRAME_SIZE_RST)
    else $error("frame size not at reset value");
endmodule : flbs_sequencer_properties

bind flbs_sequencer flbs_sequencer_properties i_props (
  .clock_i(clock_i),
  .reset_n_i(reset_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .tx_frame_o(tx_frame_o),
  .tx_frame_bytes_o(tx_frame_bytes_o),
  .busy_o(busy_o),
  .done_o(done_o)
);

// ==== tb/flbs_sequencer_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the test sequencer
module flbs_sequencer_tb
  import flbs_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, tx_frame_o, tx_sent_i, rx_frame_i, busy_o, done_o;
  logic [15:0] tx_frame_bytes_o;
  logic [15:0] buf_cap = 16'hffff;
  logic [31:0] rd;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int run_len = 0;
  int max_run = 0;
  int busy_len = 0;
  // Enable bits only; the start bit is added by go()
  localparam logic [31:0] LOSS_EN = 32'h1;
  localparam logic [31:0] BURST_EN = 32'h2;

  // Short second keeps each trial at 20 cycles
  flbs_sequencer #(.SEC_CYCLES(20)) i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_frame_o(tx_frame_o),
    .tx_frame_bytes_o(tx_frame_bytes_o), .tx_sent_i(tx_sent_i), .rx_frame_i(rx_frame_i),
    .busy_o(busy_o), .done_o(done_o));
  flbs_dut_model i_model (.clock_i(clock_i), .reset_n_i(reset_n_i), .tx_frame_i(tx_frame_o),
    .buf_cap_i(buf_cap), .tx_sent_o(tx_sent_i), .rx_frame_o(rx_frame_i));

  // Clock
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  // Timeout and longest back-to-back run
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    run_len <= tx_frame_o ? run_len + 1 : 0;
    if (tx_frame_o && run_len + 1 > max_run) max_run <= run_len + 1;
    busy_len <= busy_o ? busy_len + 1 : (done_o ? busy_len : 0); // Held while done, cleared when idle
    if (cycles == 40000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : check

  // Bus cycle: hold until waitrequest is seen low at a rising edge
  task automatic av_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
  endtask : av_cycle

  task automatic wait_done();
    @(posedge clock_i);
    while (done_o !== 1'b1) @(posedge clock_i);
  endtask : wait_done

  // Enables go in first: the start bit only sees enables already stored
  task automatic go(input logic [31:0] en);
    av_cycle(1'b1, FLBS_REG_CTRL, en);
    av_cycle(1'b1, FLBS_REG_CTRL, en | 32'h4);
  endtask : go

  task automatic t_reset();
    logic [3:0] a[8] = '{FLBS_REG_STATUS, FLBS_REG_LOSS_STEP, FLBS_REG_TRIAL_SEC, FLBS_REG_FRAME_SIZE,
      FLBS_REG_CEILING, FLBS_REG_THRESH, FLBS_REG_ITER, 4'he};
    logic [31:0] e[8] = '{32'h0, 32'(FLBS_LOSS_STEP_RST), 32'(FLBS_TRIAL_SEC_RST),
      32'(FLBS_FRAME_SIZE_RST), FLBS_CEILING_RST, FLBS_THRESH_RST, 32'(FLBS_ITER_RST), 32'h0};
    for (int i = 0; i < 8; i++) begin
      av_cycle(1'b0, a[i], 32'h0);
      check(rd, e[i]);
    end
    $display("test reset values done");
  endtask : t_reset

  task automatic t_gate();
    go(32'h0);
    repeat (3) @(posedge clock_i);
    check({31'h0, busy_o}, 32'h0);
    check(32'(max_run), 32'h0);
    // With no enable the start falls straight through to done
    av_cycle(1'b0, FLBS_REG_STATUS, 32'h0);
    check(rd, {26'h0, 1'b1, 1'b0, 1'b0, FLBS_DONE});
    av_cycle(1'b1, FLBS_REG_CTRL, 32'h0);
    $display("test enable gating done");
  endtask : t_gate

  task automatic t_loss_clean();
    buf_cap <= 16'hffff;
    av_cycle(1'b1, FLBS_REG_TRIAL_SEC, 32'h1);
    go(LOSS_EN);
    av_cycle(1'b0, FLBS_REG_RATE, 32'h0);
    check(rd, 32'(FLBS_FULL_RATE_PCT));
    wait_done();
    // Two clean trials of 20 cycles, each followed by one decision cycle
    check(32'(busy_len), 32'h2a);
    av_cycle(1'b0, FLBS_REG_RATE, 32'h0);
    check(rd, 32'(FLBS_FULL_RATE_PCT - FLBS_LOSS_STEP_RST));
    av_cycle(1'b0, FLBS_REG_LOSS_PPM, 32'h0);
    check(rd, 32'h0);
    av_cycle(1'b1, FLBS_REG_CTRL, 32'h0);
    check({31'h0, done_o}, 32'h0);
    $display("test clean loss sweep done");
  endtask : t_loss_clean

  task automatic t_loss_drop();
    buf_cap <= 16'h0;
    av_cycle(1'b1, FLBS_REG_LOSS_STEP, 32'h1e);
    go(LOSS_EN);
    wait_done();
    av_cycle(1'b0, FLBS_REG_LOSS_PPM, 32'h0);
    check(rd, 32'h000f4240);
    // Every trial loses: 100, 70, 40, then 10 is not above the step of 30
    av_cycle(1'b0, FLBS_REG_RATE, 32'h0);
    check(rd, 32'h0000000a);
    av_cycle(1'b1, FLBS_REG_CTRL, 32'h0);
    $display("test lossy sweep done");
  endtask : t_loss_drop

  task automatic t_burst(input logic [15:0] cap, input logic [31:0] lo, input logic [31:0] hi);
    buf_cap <= cap;
    av_cycle(1'b1, FLBS_REG_CEILING, 32'h8);
    av_cycle(1'b1, FLBS_REG_ITER, 32'h2);
    go(BURST_EN);
    wait_done();
    av_cycle(1'b0, FLBS_REG_BURST_RES, 32'h0);
    check({31'h0, rd >= lo && rd <= hi}, 32'h1);
    av_cycle(1'b0, FLBS_REG_BURST_LEN, 32'h0);
    check({31'h0, rd <= 32'h8}, 32'h1);
    // First burst starts at the ceiling of 8 and goes out back to back
    check(32'(max_run), 32'h8);
    av_cycle(1'b1, FLBS_REG_CTRL, 32'h0);
    $display("test burst search done");
  endtask : t_burst

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_gate();
    t_loss_clean();
    t_loss_drop();
    t_burst(16'h5, 32'h1, 32'h5);
    t_burst(16'h10, 32'h8, 32'h8);
    final_report();
  end
endmodule : flbs_sequencer_tb
